// ### gpm_ports.sv
// Ports A, B and C with alternate functions, pin interrupts and the miscellaneous register.
// How it works
// - Data latch writes always land, any direction.
// - Reads return latch for outputs, pin otherwise.
// - Open-drain outputs read back the pin level.
// - Direction bit per pin: zero input, one output.
// - Ports A and B reset to zero.
// - Port C has three bits; upper bits read ones.
// - Data at even index, direction at next odd.
// - A1 and A2 are plain open-drain pins.
// - A4-A7 interrupt inputs, captures, compare outputs.
// - B4-B7 interrupt inputs; port B push-pull.
// - Clock-output select drives CPU clock on A0.
// - USB enable bit routes transmit enable out.
// - Slow bit sets only; halves CPU clock.
// - Peripheral outputs override latch and direction.
// - Output pins never raise pin interrupts.
// - Inputs 1,2,5,6 rise; 3,4,7,8 fall.
// - Unmasked pin interrupts OR into one request.
`timescale 1ns/100ps

module gpm_ports
	import gpm_pkg::*;
#(
	parameter int ADDR_W    = 8,
	parameter bit SMALL_PKG = 1'b0
)(
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              rst_b,
	// APB slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output wire logic [31:0]       prdata,
	output wire logic              pready,
	output wire logic              pslverr,
	// Port A pins
	input  wire logic [7:0]        portaIn,
	output wire logic [7:0]        portaOut,
	output wire logic [7:0]        portaOe,
	// Port B pins
	input  wire logic [7:0]        portbIn,
	output wire logic [7:0]        portbOut,
	output wire logic [7:0]        portbOe,
	// Port C pins
	input  wire logic [2:0]        portcIn,
	output wire logic [2:0]        portcOut,
	output wire logic [2:0]        portcOe,
	// Timer
	input  wire logic              compareOut1Enable,
	input  wire logic              compareOut2Enable,
	input  wire logic              timerCompareOut1,
	input  wire logic              timerCompareOut2,
	output wire logic              timerCaptureIn1,
	output wire logic              timerCaptureIn2,
	output wire logic              timerExternalClockIn,
	// Serial interface
	input  wire logic              serialEnable,
	input  wire logic              serialTransmitData,
	output wire logic              serialReceivePin,
	// USB and clocking
	input  wire logic              usbTransmitting,
	output wire logic              cpuClockEnable,
	output wire logic              slowClockSelect,
	// Interrupt
	output wire logic              irq
);

	// ========================================
	// State
	typedef struct packed {
		logic [7:0]  paLatch;
		logic [7:0]  paDir;
		logic [7:0]  pbLatch;
		logic [7:0]  pbDir;
		logic [2:0]  pcLatch;
		logic [2:0]  pcDir;
		logic [7:0]  irqEn;
		logic [2:0]  misc;
		logic [7:0]  status;
		logic [7:0]  mask;
		logic [7:0]  irqPrev;
		logic [7:0]  paOut;
		logic [7:0]  paOe;
		logic [7:0]  pbOut;
		logic [7:0]  pbOe;
		logic [2:0]  pcOut;
		logic [2:0]  pcOe;
		logic        clkPhase;
		logic        cpuEn;
		logic        cap1;
		logic        cap2;
		logic        timer_external_clock_in;
		logic        rx;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
		logic        irq;
	} gpm_state_s;

	gpm_state_s st_reg;
	gpm_state_s st_next;

	logic [1:0]  rstSync_reg;
	logic        rstInt_b;
	logic [18:0] pinSync;
	logic [7:0]  syncA;
	logic [7:0]  syncB;
	logic [2:0]  syncC;
	logic [3:0]  idx;
	logic        mapped;
	logic        rdCapture;
	logic        apbDone;
	logic [7:0]  altA;
	logic [7:0]  altB;
	logic [2:0]  altC;
	logic [7:0]  dirEffA;
	logic [7:0]  dirEffB;
	logic [2:0]  dirEffC;
	logic [7:0]  irqLevel;
	logic [7:0]  armed;
	logic [7:0]  irqEvent;
	logic [7:0]  rdByte;
	logic [7:0]  rdPortC;
	logic [7:0]  statClr;
	logic        usb_tx_enable_output;

	// Pins seen as outputs read the latch; open-drain outputs read the pin.
	function automatic logic [7:0] readPort(input logic [7:0] latch, input logic [7:0] dir,
		input logic [7:0] pin, input logic [7:0] od);
		logic [7:0] useLatch;
		useLatch = dir & ~od;
		return (latch & useLatch) | (pin & ~useLatch);
	endfunction

	// ========================================
	// Reset release and pin synchronisers
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rstSync_reg <= 2'h0;
		end else begin
			rstSync_reg <= {rstSync_reg[0], 1'b1};
		end
	end

	assign rstInt_b = rstSync_reg[1];

	gpm_sync #(
		.WIDTH(19)
	) u_sync (
		.clk     (clk),
		.rstInt_b(rstInt_b),
		.asyncIn ({portcIn, portbIn, portaIn}),
		.syncOut (pinSync)
	);

	assign syncA = pinSync[7:0];
	assign syncB = pinSync[15:8];
	assign syncC = pinSync[18:16];

	// ========================================
	// Bus decode
	assign idx       = paddr[IDX_MSB:IDX_LSB];
	assign mapped    = (paddr[1:0] == 2'h0) && ((paddr >> (IDX_MSB + 1)) == '0) &&
		(idx <= IDX_PC_DIR || idx >= IDX_IRQ_EN);
	assign rdCapture = psel && penable && !st_reg.pready;
	assign apbDone   = psel && penable && st_reg.pready;
	assign usb_tx_enable_output     = st_reg.misc[MISC_USB_TX] && usbTransmitting;

	// ========================================
	// Alternate functions and pin interrupts
	always_comb begin
		altA = 8'h00;
		altB = 8'h00;
		altC = 3'h0;
		altA[PA_CLKOUT] = st_reg.misc[MISC_CLKOUT];
		altA[PA_CMP1]   = compareOut1Enable;
		altA[PA_CMP2]   = compareOut2Enable;
		altB[PB_USB_TX] = SMALL_PKG && st_reg.misc[MISC_USB_TX];
		altC[PC_TX]     = serialEnable;
		altC[PC_USB_TX] = !SMALL_PKG && st_reg.misc[MISC_USB_TX];
		dirEffA  = st_reg.paDir | altA;
		dirEffB  = st_reg.pbDir | altB;
		dirEffC  = st_reg.pcDir | altC;
		irqLevel = {syncB[7:4], syncA[7:4]};
		armed    = st_reg.irqEn & ~{dirEffB[7:4], dirEffA[7:4]};
		irqEvent = armed & (((irqLevel & ~st_reg.irqPrev) & RISING_EDGE) |
			((~irqLevel & st_reg.irqPrev) & ~RISING_EDGE));
	end

	// ========================================
	// Register read mux
	always_comb begin
		rdByte  = 8'h00;
		rdPortC = readPort({5'h00, st_reg.pcLatch}, {5'h00, st_reg.pcDir}, {5'h00, syncC}, 8'h00);
		case (idx)
			IDX_PA_DATA:  rdByte = readPort(st_reg.paLatch, st_reg.paDir, syncA, OPEN_DRAIN_A);
			IDX_PA_DIR:   rdByte = st_reg.paDir;
			IDX_PB_DATA:  rdByte = readPort(st_reg.pbLatch, st_reg.pbDir, syncB, 8'h00);
			IDX_PB_DIR:   rdByte = st_reg.pbDir;
			IDX_PC_DATA:  rdByte = {PC_UNUSED_RD, rdPortC[2:0]};
			IDX_PC_DIR:   rdByte = {PC_UNUSED_RD, st_reg.pcDir};
			IDX_IRQ_EN:   rdByte = st_reg.irqEn;
			IDX_MISC:     rdByte = {MISC_RSVD_RD, st_reg.misc};
			IDX_IRQ_STAT: rdByte = st_reg.status;
			IDX_IRQ_MASK: rdByte = st_reg.mask;
			default:      rdByte = 8'h00;
		endcase
	end

	// ========================================
	// Next state
	always_comb begin
		st_next = st_reg;
		statClr = 8'h00;

		// Bus answers one cycle into the access phase.
		st_next.pready  = psel && penable && !st_reg.pready;
		st_next.pslverr = rdCapture && !mapped;
		if (rdCapture) begin
			st_next.prdata = (mapped && !pwrite) ? {24'h000000, rdByte} : 32'h00000000;
		end

		if (apbDone && pwrite && mapped) begin
			case (idx)
				IDX_PA_DATA:  st_next.paLatch = pwdata[7:0];
				IDX_PA_DIR:   st_next.paDir   = pwdata[7:0];
				IDX_PB_DATA:  st_next.pbLatch = pwdata[7:0];
				IDX_PB_DIR:   st_next.pbDir   = pwdata[7:0];
				IDX_PC_DATA:  st_next.pcLatch = pwdata[2:0];
				IDX_PC_DIR:   st_next.pcDir   = pwdata[2:0];
				IDX_IRQ_EN:   st_next.irqEn   = pwdata[7:0];
				IDX_MISC: begin
					st_next.misc[MISC_CLKOUT] = pwdata[MISC_CLKOUT];
					st_next.misc[MISC_USB_TX] = pwdata[MISC_USB_TX];
					st_next.misc[MISC_SLOW]   = st_reg.misc[MISC_SLOW] | pwdata[MISC_SLOW];
				end
				IDX_IRQ_MASK: st_next.mask    = pwdata[7:0];
				default: begin
				end
			endcase
		end

		// Only the bits actually returned are cleared, so an event landing between
		// capture and completion survives; a new event also beats the clear.
		if (apbDone && !pwrite && mapped && idx == IDX_IRQ_STAT) begin
			statClr = st_reg.prdata[7:0];
		end
		st_next.irqPrev = irqLevel;
		st_next.status  = (st_reg.status & ~statClr) | irqEvent;
		st_next.irq     = |(st_next.status & st_next.mask);

		// The slow stage gates every second cycle; the USB side keeps its own clock.
		st_next.cpuEn = st_reg.misc[MISC_SLOW] ? !st_reg.cpuEn : 1'b1;
		if (st_reg.cpuEn) begin
			st_next.clkPhase = !st_reg.clkPhase;
		end

		// Port A: open-drain pins only ever pull low.
		st_next.paOut = st_reg.paLatch;
		st_next.paOut[PA_CLKOUT] = st_reg.misc[MISC_CLKOUT] ? st_reg.clkPhase : st_reg.paLatch[PA_CLKOUT];
		st_next.paOut[PA_CMP1]   = compareOut1Enable ? timerCompareOut1 : st_reg.paLatch[PA_CMP1];
		st_next.paOut[PA_CMP2]   = compareOut2Enable ? timerCompareOut2 : st_reg.paLatch[PA_CMP2];
		st_next.paOut = st_next.paOut & ~OPEN_DRAIN_A;
		st_next.paOe  = (dirEffA & ~OPEN_DRAIN_A) | (st_reg.paDir & OPEN_DRAIN_A & ~st_reg.paLatch);

		st_next.pbOut = st_reg.pbLatch;
		st_next.pbOut[PB_USB_TX] = altB[PB_USB_TX] ? usb_tx_enable_output : st_reg.pbLatch[PB_USB_TX];
		st_next.pbOe  = dirEffB;

		st_next.pcOut = st_reg.pcLatch;
		st_next.pcOut[PC_TX]    = serialEnable ? serialTransmitData : st_reg.pcLatch[PC_TX];
		st_next.pcOut[PC_USB_TX] = altC[PC_USB_TX] ? usb_tx_enable_output : st_reg.pcLatch[PC_USB_TX];
		st_next.pcOe  = dirEffC;

		st_next.cap1   = syncA[PA_CAP1];
		st_next.cap2   = syncA[PA_CAP2];
		st_next.timer_external_clock_in = syncA[PA_TMR_CLK];
		st_next.rx     = syncC[PC_RX];
	end

	always_ff @(posedge clk or negedge rstInt_b) begin
		if (!rstInt_b) begin
			st_reg         <= '0;
			st_reg.paLatch <= PORT_RESET;
			st_reg.paDir   <= PORT_RESET;
			st_reg.pbLatch <= PORT_RESET;
			st_reg.pbDir   <= PORT_RESET;
			st_reg.pcLatch <= PC_RESET;
			st_reg.pcDir   <= PC_RESET;
			st_reg.cpuEn   <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	// ========================================
	// Outputs
	assign prdata               = st_reg.prdata;
	assign pready               = st_reg.pready;
	assign pslverr              = st_reg.pslverr;
	assign portaOut             = st_reg.paOut;
	assign portaOe              = st_reg.paOe;
	assign portbOut             = st_reg.pbOut;
	assign portbOe              = st_reg.pbOe;
	assign portcOut             = st_reg.pcOut;
	assign portcOe              = st_reg.pcOe;
	assign timerCaptureIn1      = st_reg.cap1;
	assign timerCaptureIn2      = st_reg.cap2;
	assign timerExternalClockIn = st_reg.timer_external_clock_in;
	assign serialReceivePin     = st_reg.rx;
	assign cpuClockEnable       = st_reg.cpuEn;
	assign slowClockSelect      = st_reg.misc[MISC_SLOW];
	assign irq                  = st_reg.irq;

	if (ADDR_W < IDX_MSB + 1) begin : g_addr_check
		$error("gpm_ports needs at least six address bits");
	end

	// ========================================
	// Checks
	property p_latch_write;
		@(posedge clk) disable iff (!rstInt_b)
		(apbDone && pwrite && mapped && idx == IDX_PA_DATA) |=> (st_reg.paLatch == $past(pwdata[7:0]));
	endproperty
	a_latch_write: assert property (p_latch_write) else $error("Port A latch missed a write");

	property p_read_input;
		@(posedge clk) disable iff (!rstInt_b)
		(rdCapture && !pwrite && idx == IDX_PB_DATA && st_reg.pbDir == 8'h00 && paddr[1:0] == 2'h0 &&
			(paddr >> (IDX_MSB + 1)) == '0) |=> (prdata[7:0] == $past(syncB));
	endproperty
	a_read_input: assert property (p_read_input) else $error("Input read did not return pins");

	property p_open_drain_read;
		@(posedge clk) disable iff (!rstInt_b)
		(rdCapture && !pwrite && mapped && idx == IDX_PA_DATA && st_reg.paDir[1]) |=> (prdata[1] == $past(syncA[1]));
	endproperty
	a_open_drain_read: assert property (p_open_drain_read) else $error("Open-drain read gave latch");

	property p_reset_values;
		@(posedge clk) disable iff (!rstInt_b)
		$rose(rstInt_b) |-> (st_reg.paDir == 8'h00 && st_reg.pbDir == 8'h00 && st_reg.paLatch == 8'h00);
	endproperty
	a_reset_values: assert property (p_reset_values) else $error("Ports not cleared by reset");

	property p_portc_upper;
		@(posedge clk) disable iff (!rstInt_b)
		(rdCapture && !pwrite && mapped && idx == IDX_PC_DIR) |=> (prdata[7:3] == 5'h1F);
	endproperty
	a_portc_upper: assert property (p_portc_upper) else $error("Port C upper bits not ones");

	property p_open_drain_low;
		@(posedge clk) disable iff (!rstInt_b)
		(portaOe[1] || portaOe[2]) |-> (portaOut[2:1] == 2'h0);
	endproperty
	a_open_drain_low: assert property (p_open_drain_low) else $error("Open-drain pin driven high");

	property p_clkout_drive;
		@(posedge clk) disable iff (!rstInt_b)
		st_reg.misc[MISC_CLKOUT] |=> portaOe[PA_CLKOUT];
	endproperty
	a_clkout_drive: assert property (p_clkout_drive) else $error("Clock output pin not driven");

	property p_slow_sticky;
		@(posedge clk) disable iff (!rstInt_b)
		slowClockSelect |=> slowClockSelect [*2];
	endproperty
	a_slow_sticky: assert property (p_slow_sticky) else $error("Slow select cleared without reset");

	property p_rise_event;
		@(posedge clk) disable iff (!rstInt_b)
		(armed[0] && syncA[PA_CAP1] && !st_reg.irqPrev[0]) |=> st_reg.status[0];
	endproperty
	a_rise_event: assert property (p_rise_event) else $error("Rising edge not flagged");

	property p_output_no_irq;
		@(posedge clk) disable iff (!rstInt_b)
		(dirEffB[4] && !st_reg.status[4]) |=> !st_reg.status[4];
	endproperty
	a_output_no_irq: assert property (p_output_no_irq) else $error("Output pin raised interrupt");

	property p_irq_or;
		@(posedge clk) disable iff (!rstInt_b)
		irq == |(st_reg.status & st_reg.mask);
	endproperty
	a_irq_or: assert property (p_irq_or) else $error("Interrupt line disagrees with status");

endmodule

// ### gpm_pkg.sv
// Shared constants for the general-purpose port block.
package gpm_pkg;

	// ========================================
	// Register indices; byte address is four times the index.
	localparam logic [3:0] IDX_PA_DATA  = 4'h0;
	localparam logic [3:0] IDX_PA_DIR   = 4'h1;
	localparam logic [3:0] IDX_PB_DATA  = 4'h2;
	localparam logic [3:0] IDX_PB_DIR   = 4'h3;
	localparam logic [3:0] IDX_PC_DATA  = 4'h4;
	localparam logic [3:0] IDX_PC_DIR   = 4'h5;
	localparam logic [3:0] IDX_IRQ_EN   = 4'h8;
	localparam logic [3:0] IDX_MISC     = 4'h9;
	localparam logic [3:0] IDX_IRQ_STAT = 4'hA;
	localparam logic [3:0] IDX_IRQ_MASK = 4'hB;
	localparam int         IDX_LSB      = 2;
	localparam int         IDX_MSB      = 5;

	// ========================================
	// Fields and reset values
	localparam int         MISC_CLKOUT  = 0;
	localparam int         MISC_USB_TX  = 1;
	localparam int         MISC_SLOW    = 2;
	localparam logic [7:0] PORT_RESET   = 8'h00;
	localparam logic [2:0] PC_RESET     = 3'h0;
	localparam logic [4:0] PC_UNUSED_RD = 5'h1F;
	localparam logic [4:0] MISC_RSVD_RD = 5'h1E;
	localparam logic [7:0] OPEN_DRAIN_A = 8'h06;
	localparam logic [7:0] RISING_EDGE  = 8'h33;

	// ========================================
	// Pin positions of alternate functions
	localparam int PA_CLKOUT = 0;
	localparam int PA_TMR_CLK = 3;
	localparam int PA_CAP1   = 4;
	localparam int PA_CAP2   = 5;
	localparam int PA_CMP1   = 6;
	localparam int PA_CMP2   = 7;
	localparam int PB_USB_TX = 1;
	localparam int PC_RX     = 0;
	localparam int PC_TX     = 1;
	localparam int PC_USB_TX = 2;

endpackage

// ### gpm_sync.sv
// Two-stage synchroniser for pin levels.
`timescale 1ns/100ps

module gpm_sync
	import gpm_pkg::*;
#(
	parameter int WIDTH = 19
)(
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rstInt_b,
	// Levels
	input  wire logic [WIDTH-1:0] asyncIn,
	output wire logic [WIDTH-1:0] syncOut
);

	typedef struct packed {
		logic [WIDTH-1:0] stage1;
		logic [WIDTH-1:0] stage2;
	} gpm_sync_s;

	gpm_sync_s st_reg;
	gpm_sync_s st_next;

	// Stage one feeds only stage two, so no logic sees a metastable level.
	always_comb begin
		st_next        = st_reg;
		st_next.stage1 = asyncIn;
		st_next.stage2 = st_reg.stage1;
	end

	always_ff @(posedge clk or negedge rstInt_b) begin
		if (!rstInt_b) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign syncOut = st_reg.stage2;

	if (WIDTH < 1) begin : g_width_check
		$error("gpm_sync needs a width of at least one");
	end

endmodule

// ### gpm_board.sv
// Board model that resolves the level on every port pin.
`timescale 1ns/100ps

module gpm_board (
	// Pin drivers of the block
	input  wire logic [7:0] portaOut,
	input  wire logic [7:0] portaOe,
	input  wire logic [7:0] portbOut,
	input  wire logic [7:0] portbOe,
	input  wire logic [2:0] portcOut,
	input  wire logic [2:0] portcOe,
	// Levels the board puts on released pins
	input  wire logic [7:0] extA,
	input  wire logic [7:0] extB,
	input  wire logic [2:0] extC,
	// Resolved levels
	output wire logic [7:0] portaIn,
	output wire logic [7:0] portbIn,
	output wire logic [2:0] portcIn
);
	// ========================================
	// Wire resolution
	// An open-drain pin only pulls low, so the same formula covers it.
	assign portaIn = (portaOe & portaOut) | (~portaOe & extA);
	assign portbIn = (portbOe & portbOut) | (~portbOe & extB);
	assign portcIn = (portcOe & portcOut) | (~portcOe & extC);
endmodule

// ### tb.sv
// Self-checking testbench of the general-purpose port block.
`timescale 1ns/100ps

module tb
	import gpm_pkg::*;
();
	// ========================================
	// Signals
	logic        clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]  paddr = 8'h00, extA = 8'hC9, extB = 8'hC3;
	logic [31:0] pwdata = 32'h00000000;
	logic [2:0]  extC = 3'h5;
	logic        cmp1En = 0, cmp2En = 0, cmp1 = 0, cmp2 = 0, serEn = 0, serTx = 0, usbTx = 0;
	wire  [31:0] prdata;
	wire         pready, pslverr, cap1, cap2, timer_external_clock_in, serRx, cpuEn, slowSel, irq;
	wire  [7:0]  portaIn, portaOut, portaOe, portbIn, portbOut, portbOe;
	wire  [2:0]  portcIn, portcOut, portcOe;
	int          mismatches = 0, n_tests = 0, cycles = 0;

	always #20 clk = ~clk;

	gpm_ports uut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.portaIn(portaIn), .portaOut(portaOut), .portaOe(portaOe), .portbIn(portbIn),
		.portbOut(portbOut), .portbOe(portbOe), .portcIn(portcIn), .portcOut(portcOut),
		.portcOe(portcOe), .compareOut1Enable(cmp1En), .compareOut2Enable(cmp2En),
		.timerCompareOut1(cmp1), .timerCompareOut2(cmp2), .timerCaptureIn1(cap1),
		.timerCaptureIn2(cap2), .timerExternalClockIn(timer_external_clock_in), .serialEnable(serEn),
		.serialTransmitData(serTx), .serialReceivePin(serRx), .usbTransmitting(usbTx),
		.cpuClockEnable(cpuEn), .slowClockSelect(slowSel), .irq(irq));

	gpm_board board (.portaOut(portaOut), .portaOe(portaOe), .portbOut(portbOut),
		.portbOe(portbOe), .portcOut(portcOut), .portcOe(portcOe), .extA(extA), .extB(extB),
		.extC(extC), .portaIn(portaIn), .portbIn(portbIn), .portcIn(portcIn));

	// ========================================
	// Helpers
	task automatic close_out();
		if (mismatches == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// The whole run needs a few hundred cycles; this ceiling only catches a hang.
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			mismatches++;
			close_out();
		end
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic apb(input logic wr, input logic [3:0] idx, input logic [7:0] wd,
		output logic [7:0] rd, output logic err);
		@(posedge clk);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= {2'h0, idx, 2'h0};
		pwdata <= {24'h000000, wd};
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata[7:0];
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [3:0] idx, input logic [7:0] d);
		logic [7:0] r;
		logic       e;
		apb(1'b1, idx, d, r, e);
	endtask

	task automatic rdchk(input logic [3:0] idx, input logic [7:0] exp);
		logic [7:0] r;
		logic       e;
		apb(1'b0, idx, 8'h00, r, e);
		chk(r, exp);
	endtask

	task automatic flip(input int i);
		if (i < 4) begin
			extA[i + 4] <= ~extA[i + 4];
		end else begin
			extB[i] <= ~extB[i];
		end
	endtask

	// ========================================
	// Scenarios
	task automatic t_reset();
		rdchk(IDX_PA_DIR, 8'h00);
		rdchk(IDX_PB_DIR, 8'h00);
		rdchk(IDX_PC_DIR, 8'hF8);
		rdchk(IDX_PC_DATA, 8'hFD);
		rdchk(IDX_PA_DATA, 8'hC9);
		rdchk(IDX_MISC, 8'hF0);
		chk(portbOe, 8'h00);
		chk({7'h00, timer_external_clock_in}, 8'h01);
		chk({7'h00, cpuEn}, 8'h01);
	endtask

	task automatic t_port();
		logic [7:0] r;
		logic       e;
		wr(IDX_PB_DATA, 8'hA5);
		rdchk(IDX_PB_DATA, 8'hC3);
		wr(IDX_PB_DIR, 8'h0F);
		cyc(4);
		chk(portbOe, 8'h0F);
		chk(portbOut & 8'h0F, 8'h05);
		rdchk(IDX_PB_DATA, 8'hC5);
		wr(IDX_PB_DIR, 8'h00);
		wr(IDX_PA_DATA, 8'h02);
		wr(IDX_PA_DIR, 8'h06);
		cyc(4);
		chk(portaOe, 8'h04);
		chk(portaOut, 8'h00);
		rdchk(IDX_PA_DATA, 8'hC9);
		wr(IDX_PA_DIR, 8'h00);
		apb(1'b0, 4'h6, 8'h00, r, e);
		chk({7'h00, e}, 8'h01);
		chk(r, 8'h00);
		apb(1'b1, 4'h7, 8'h55, r, e);
		chk({7'h00, e}, 8'h01);
	endtask

	task automatic t_alt();
		logic a;
		logic seen;
		cmp1En <= 1'b1;
		cmp1   <= 1'b1;
		cmp2En <= 1'b1;
		cmp2   <= 1'b1;
		serEn  <= 1'b1;
		serTx  <= 1'b1;
		usbTx  <= 1'b1;
		wr(IDX_MISC, 8'h03);
		cyc(4);
		chk(portaOe & 8'hC1, 8'hC1);
		chk({7'h00, portaOut[6]}, 8'h01);
		chk({6'h00, portaOut[7:6]}, 8'h03);
		chk({5'h00, portcOe}, 8'h06);
		chk({5'h00, portcOut}, 8'h06);
		chk({7'h00, serRx}, 8'h01);
		a = portaOut[0];
		seen = 1'b0;
		repeat (4) begin
			@(posedge clk);
			if (portaOut[0] !== a) seen = 1'b1;
		end
		chk({7'h00, seen}, 8'h01);
		usbTx <= 1'b0;
		cyc(3);
		chk({7'h00, portcOut[2]}, 8'h00);
		cmp1En <= 1'b0;
		cmp2En <= 1'b0;
		serEn  <= 1'b0;
		wr(IDX_MISC, 8'h00);
		cyc(4);
		chk(portaOe, 8'h00);
		chk({5'h00, portcOe}, 8'h00);
	endtask

	task automatic t_irq();
		wr(IDX_IRQ_EN, 8'hFF);
		wr(IDX_IRQ_MASK, 8'hFF);
		cyc(8);
		rdchk(IDX_IRQ_STAT, 8'h00);
		for (int i = 0; i < 8; i++) begin
			flip(i);
			cyc(8);
			chk({7'h00, irq}, 8'h01);
			rdchk(IDX_IRQ_STAT, 8'h01 << i);
			if (i == 0) chk({7'h00, cap1}, 8'h01);
			if (i == 1) chk({7'h00, cap2}, 8'h01);
			cyc(2);
			chk({7'h00, irq}, 8'h00);
			flip(i);
			cyc(8);
			rdchk(IDX_IRQ_STAT, 8'h00);
		end
		wr(IDX_IRQ_MASK, 8'h00);
		flip(0);
		cyc(8);
		chk({7'h00, irq}, 8'h00);
		rdchk(IDX_IRQ_STAT, 8'h01);
		flip(0);
		wr(IDX_IRQ_MASK, 8'hFF);
		wr(IDX_PB_DIR, 8'h10);
		wr(IDX_PB_DATA, 8'h10);
		cyc(8);
		rdchk(IDX_IRQ_STAT, 8'h00);
		wr(IDX_PB_DIR, 8'h00);
		wr(IDX_IRQ_EN, 8'h00);
		flip(0);
		cyc(8);
		rdchk(IDX_IRQ_STAT, 8'h00);
		chk({7'h00, irq}, 8'h00);
	endtask

	task automatic t_slow();
		logic a;
		logic seen;
		wr(IDX_MISC, 8'h04);
		cyc(2);
		chk({7'h00, slowSel}, 8'h01);
		a = cpuEn;
		seen = 1'b0;
		repeat (4) begin
			@(posedge clk);
			if (cpuEn !== a) seen = 1'b1;
		end
		chk({7'h00, seen}, 8'h01);
		wr(IDX_MISC, 8'h00);
		rdchk(IDX_MISC, 8'hF4);
		chk({7'h00, slowSel}, 8'h01);
	endtask

	// ========================================
	// Main sequence
	initial begin
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		cyc(6);
		t_reset();
		t_port();
		t_alt();
		t_irq();
		t_slow();
		close_out();
	end
endmodule
